// >>> uart_ch_regs.svh
/*
  Register offsets, field positions, masks and reset values of one
  serial channel's register block.
  Assumes inclusion by bare name from the channel's design files.
*/
`ifndef UART_CH_REGS_SVH
`define UART_CH_REGS_SVH

// register offsets on the 4-bit host address
`define OFS_RXHOLD     4'h0
`define OFS_IMASK      4'h1
`define OFS_ISRC       4'h2
`define OFS_LINE_CTL   4'h3
`define OFS_MODEM_CTL  4'h4
`define OFS_LINE_STAT  4'h5
`define OFS_MODEM_STAT 4'h6
`define OFS_SCRATCH    4'h7
`define OFS_FEAT       4'h8
`define OFS_ENH        4'h9
`define OFS_TX_LVL     4'ha
`define OFS_RX_LVL     4'hb
`define OFS_FLOW_STAT  4'hc
`define OFS_STOP2      4'hd
`define OFS_RESUME1    4'he
`define OFS_RESUME2    4'hf

// single bit positions
`define FEN_BIT    0
`define RXRST_BIT  1
`define TXRST_BIT  2
`define DIV_EN_BIT 7
`define ENH_EN_BIT 4
`define LOOP_BIT   4
`define DTR_BIT    0
`define RTS_BIT    1
`define GP1_BIT    2
`define GP2_BIT    3
`define IM_RX      0
`define IM_TX      1
`define IM_LS      2
`define IM_MS      3

// multi-bit fields
`define RXT_SEL 7:6
`define TXT_SEL 5:4
`define TBL_SEL 7:6
`define TBL_CUSTOM 2'h3

// bits writable only with enhanced functions on, then reserved, kept and check masks
`define IM_EXT_MASK  8'he0
`define FC_EXT_MASK  8'h30
`define MC_EXT_MASK  8'hec
`define MSW_EXT_MASK 8'hfc
`define IM_RSVD      8'h10
`define FC_KEEP      8'hf9
`define IM_LOW       8'h0f
`define IM_RX_ONLY   8'h01

// trigger table and fifo depth
`define TRG_0 8'h01
`define TRG_1 8'h10
`define TRG_2 8'h20
`define TRG_3 8'h38
`define FIFO_DEPTH 7'h40
`define ONE_DEEP   7'h01

// interrupt source codes, low nibble
`define ISR_LS   4'h6
`define ISR_RX   4'h4
`define ISR_TX   4'h2
`define ISR_MS   4'h0
`define ISR_NONE 4'h1

// reset values
`define PIN_IDLE  4'hf
`define DRV_IDLE  2'h3

`endif

// >>> uart_ch_pkg.sv
/*
  Types shared by the serial channel register block and its helpers.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package uart_ch_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [5:0] ptr_t;
  typedef logic [6:0] cnt_t;

  // receive fifo entry: error flags above the data byte
  typedef struct packed {
    logic  brk;
    logic  fe;
    logic  pe;
    byte_t d;
  } rx_ent_s;

  // complete state of one channel
  typedef struct packed {
    byte_t imask, fifo_ctl, line_ctl, modem_ctl, scratch;
    byte_t feat, enh, tdly, tx_thr, rx_thr;
    logic [3:0][7:0] fchr;
    ptr_t rwp, rrp, twp, trp;
    cnt_t rcnt, tcnt, ecnt;
    logic ovr, lsr_p, tx_p, top_e, txv, irq;
    logic [3:0] s1, s2, s3, plv, mlv, msd, xs, isrc;
    logic [1:0] pins_n;
    byte_t rdata;
  } chan_st_s;
endpackage : uart_ch_pkg

// >>> fifo_mem.sv
/*
  Fifo storage with registered read data and write-through bypass.
  Assumes the caller presents the next read address each cycle.
*/
module fifo_mem
  import uart_ch_pkg::*;
#(
  parameter int W  = 8,
  parameter int AW = 6
) (
  input  wire logic          core_clk_i,
  input  wire logic          nrst_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [W-1:0]  wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [W-1:0]  rdata_o
);
  typedef struct packed {
    logic [(1<<AW)-1:0][W-1:0] mem;
    logic [W-1:0]              rd;
  } mem_s;

  mem_s s, n;

  // bypass so a word written into an empty fifo is seen at once
  always_comb begin
    n = s;
    if (we_i) begin
      n.mem[waddr_i] = wdata_i;
    end
    n.rd = (we_i && waddr_i == raddr_i) ? wdata_i : s.mem[raddr_i];
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign rdata_o = s.rd;
endmodule : fifo_mem

// >>> skid_buf.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes source and sink share the core clock.
*/
module skid_buf
  import uart_ch_pkg::*;
#(
  parameter int W = 11
) (
  input  wire logic         core_clk_i,
  input  wire logic         nrst_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic      [W-1:0] out_data_o,
  input  wire logic         out_ready_i
);
  typedef struct packed {
    logic [W-1:0] d0, d1;
    logic         v0, v1;
    logic         rdy;
  } sk_s;

  sk_s  s, n;
  logic push, pop;

  // ready comes from a flop, so a stall never forms a loop
  always_comb begin
    n = s;
    push = in_valid_i & ~s.v1;
    pop = s.v0 & out_ready_i;
    if (pop) begin
      n.d0 = s.d1;
      n.v0 = s.v1;
      n.v1 = 1'b0;
    end
    if (push) begin
      if (!n.v0) begin
        n.d0 = in_data_i;
        n.v0 = 1'b1;
      end else begin
        n.d1 = in_data_i;
        n.v1 = 1'b1;
      end
    end
    // ready registered so the channel's ready output is a plain flop
    n.rdy = ~n.v1;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
      s.rdy <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign in_ready_o = s.rdy;
  assign out_valid_o = s.v0;
  assign out_data_o = s.d0;
endmodule : skid_buf

// >>> uart_channel.sv
/*
  One serial channel: host register block, receive and transmit fifos,
  line and modem status, interrupt source encoding.
  Assumes a receiver and transmitter on the core clock outside this
  block, and single-cycle host read and write strobes.
*/
`include "uart_ch_regs.svh"

module uart_channel
  import uart_ch_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        host_cs_i,
  input  wire logic        host_rd_i,
  input  wire logic        host_wr_i,
  input  wire logic [3:0]  host_addr_i,
  input  wire logic [7:0]  host_wdata_i,
  output logic      [7:0]  host_rdata_o,
  output logic             irq_o,
  output logic      [3:0]  irq_src_o,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic [2:0]  rx_err_i,
  output logic             rx_ready_o,
  output logic             tx_valid_o,
  output logic      [7:0]  tx_data_o,
  input  wire logic        tx_ready_i,
  input  wire logic        tsr_busy_i,
  input  wire logic [3:0]  modem_n_i,
  input  wire logic [3:0]  flow_evt_i,
  output logic             dtr_n_o,
  output logic             rts_n_o,
  output logic      [7:0]  line_ctrl_o,
  output logic      [7:0]  feature_ctrl_o,
  output logic      [7:0]  enh_func_o,
  output logic      [7:0]  turnaround_o,
  output logic      [31:0] flow_chars_o
);
  chan_st_s s, n;
  rx_ent_s  sk_d, rx_top;
  logic     sk_v, sk_rdy;
  logic     rd, wr, ext, fen, dl, lsr_rd;
  logic     rx_push, rx_pop, tx_push, tx_pop;
  logic     push_err, top_err, ovr_evt, ls_set;
  logic     rx_lvl, tx_clr, ls_i, rx_i, tx_i, ms_i;
  logic     fc_wr;
  logic [3:0] a, isr_lo, stable, lb;
  byte_t    w, rx_trig, tx_trig, lsr_val, isr_val;
  cnt_t     cap;

  // control bits that only move with enhanced functions enabled
  function automatic byte_t merge(input byte_t old, input byte_t nw,
                                  input byte_t m, input logic en);
    return (nw & ~m) | ((en ? nw : old) & m);
  endfunction : merge

  // fixed table, or the host's own threshold when the custom table is set
  function automatic byte_t trig_pick(input logic [1:0] tbl,
                                      input logic [1:0] sel,
                                      input byte_t own);
    byte_t t;
    case (sel)
      2'h0: t = `TRG_0;
      2'h1: t = `TRG_1;
      2'h2: t = `TRG_2;
      default: t = `TRG_3;
    endcase
    return (tbl == `TBL_CUSTOM) ? own : t;
  endfunction : trig_pick

  // receive path: two-entry buffer ahead of the fifo
  skid_buf #(.W(11)) rx_buf (
    .core_clk_i  (core_clk_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (rx_valid_i),
    .in_data_i   ({rx_err_i, rx_data_i}),
    .in_ready_o  (rx_ready_o),
    .out_valid_o (sk_v),
    .out_data_o  (sk_d),
    .out_ready_i (sk_rdy)
  );

  fifo_mem #(.W(11), .AW(6)) rx_mem (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .we_i       (rx_push),
    .waddr_i    (s.rwp),
    .wdata_i    (sk_d),
    .raddr_i    (n.rrp),
    .rdata_o    (rx_top)
  );

  fifo_mem #(.W(8), .AW(6)) tx_mem (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .we_i       (tx_push),
    .waddr_i    (s.twp),
    .wdata_i    (host_wdata_i),
    .raddr_i    (n.trp),
    .rdata_o    (tx_data_o)
  );

  // whole next-state computation
  always_comb begin
    n = s;
    a = host_addr_i;
    w = host_wdata_i;
    rd = host_cs_i & host_rd_i;
    wr = host_cs_i & host_wr_i;
    ext = s.enh[`ENH_EN_BIT];
    fen = s.fifo_ctl[`FEN_BIT];
    dl = s.line_ctl[`DIV_EN_BIT];
    cap = fen ? `FIFO_DEPTH : `ONE_DEEP;
    lsr_rd = rd & (a == `OFS_LINE_STAT);
    fc_wr = wr & ~dl & (a == `OFS_ISRC);

    // fifo moves; non-fifo mode is a one-deep fifo
    sk_rdy = s.rcnt < cap;
    rx_push = sk_v & sk_rdy;
    rx_pop = rd & ~dl & (a == `OFS_RXHOLD) & (s.rcnt != '0);
    tx_push = wr & ~dl & (a == `OFS_RXHOLD) & (s.tcnt < cap);
    tx_pop = s.txv & tx_ready_i;
    push_err = sk_d.brk | sk_d.fe | sk_d.pe;
    top_err = (s.rcnt != '0) & (rx_top.brk | rx_top.fe | rx_top.pe);
    ovr_evt = rx_valid_i & ~rx_ready_o;

    n.rwp = s.rwp + ptr_t'(rx_push);
    n.rrp = s.rrp + ptr_t'(rx_pop);
    n.twp = s.twp + ptr_t'(tx_push);
    n.trp = s.trp + ptr_t'(tx_pop);
    n.rcnt = s.rcnt + cnt_t'(rx_push) - cnt_t'(rx_pop);
    n.tcnt = s.tcnt + cnt_t'(tx_push) - cnt_t'(tx_pop);
    // error count covers every stored character
    n.ecnt = s.ecnt + cnt_t'(rx_push & push_err)
           - cnt_t'(rx_pop & top_err);

    // fifo resets override the moves of this cycle
    if (fc_wr && w[`RXRST_BIT]) begin
      n.rwp = '0;
      n.rrp = '0;
      n.rcnt = '0;
      n.ecnt = '0;
    end
    if (fc_wr && w[`TXRST_BIT]) begin
      n.twp = '0;
      n.trp = '0;
      n.tcnt = '0;
    end
    n.txv = n.tcnt != '0;

    // trigger levels; tx trigger select is an enhanced field
    rx_trig = trig_pick(s.feat[`TBL_SEL], s.fifo_ctl[`RXT_SEL], s.rx_thr);
    tx_trig = trig_pick(s.feat[`TBL_SEL], s.fifo_ctl[`TXT_SEL], s.tx_thr);
    // level, not sticky: drops as soon as the fill falls below
    rx_lvl = fen ? ({1'b0, s.rcnt} >= rx_trig) : (s.rcnt != '0);

    // line status word
    lsr_val = {s.ecnt != '0,
               (s.tcnt == '0) & ~tsr_busy_i,
               s.tcnt == '0,
               top_err & rx_top.brk,
               top_err & rx_top.fe,
               top_err & rx_top.pe,
               s.ovr,
               s.rcnt != '0};

    // overrun: set wins over the read that clears it
    n.ovr = (s.ovr & ~lsr_rd) | ovr_evt;

    // line interrupt: error in, overrun, or error byte reaching the top
    ls_set = (rx_push & push_err) | ovr_evt | (top_err & ~s.top_e);
    n.top_e = top_err;
    n.lsr_p = (s.lsr_p & ~lsr_rd) | ls_set;

    // modem pins: three flops, a change counts once stages 2 and 3 agree
    n.s1 = modem_n_i;
    n.s2 = s.s1;
    n.s3 = s.s2;
    stable = ~(s.s2 ^ s.s3);
    n.plv = (stable & ~s.s3) | (~stable & s.plv);
    // loopback: general outputs stand in for cd and ri
    lb = {s.modem_ctl[`GP2_BIT], s.modem_ctl[`GP1_BIT],
          s.modem_ctl[`DTR_BIT], s.modem_ctl[`RTS_BIT]};
    n.mlv = s.modem_ctl[`LOOP_BIT] ? lb : n.plv;
    n.msd = ((rd && a == `OFS_MODEM_STAT) ? 4'h0 : s.msd) | (n.mlv ^ s.mlv);

    // flow indicators latch, the read clears, a new event wins
    n.xs = ((rd && a == `OFS_FLOW_STAT) ? 4'h0 : s.xs) | flow_evt_i;

    // masked sources in priority order
    ls_i = s.imask[`IM_LS] & s.lsr_p;
    rx_i = s.imask[`IM_RX] & rx_lvl;
    tx_i = s.imask[`IM_TX] & s.tx_p;
    ms_i = s.imask[`IM_MS] & (s.msd != 4'h0);
    if (ls_i) begin
      isr_lo = `ISR_LS;
    end else if (rx_i) begin
      isr_lo = `ISR_RX;
    end else if (tx_i) begin
      isr_lo = `ISR_TX;
    end else if (ms_i) begin
      isr_lo = `ISR_MS;
    end else begin
      isr_lo = `ISR_NONE;
    end
    isr_val = {fen, fen, 2'h0, isr_lo};
    n.isrc = isr_lo;
    n.irq = ls_i | rx_i | tx_i | ms_i;

    // tx ready: below trigger, then again on empty
    tx_clr = tx_push | (rd & ~dl & (a == `OFS_ISRC) & (isr_lo == `ISR_TX));
    n.tx_p = (s.tx_p & ~tx_clr)
           | (fen & ({1'b0, s.tcnt} >= tx_trig) & ({1'b0, n.tcnt} < tx_trig))
           | ((s.tcnt != '0) & (n.tcnt == '0));

    // host reads: status side of each shared offset
    if (rd) begin
      case (a)
        `OFS_RXHOLD: n.rdata = dl ? 8'h00 : rx_top.d;
        `OFS_IMASK: n.rdata = dl ? 8'h00 : s.imask;
        `OFS_ISRC: n.rdata = dl ? 8'h00 : isr_val;
        `OFS_LINE_CTL: n.rdata = s.line_ctl;
        `OFS_MODEM_CTL: n.rdata = s.modem_ctl;
        `OFS_LINE_STAT: n.rdata = lsr_val;
        `OFS_MODEM_STAT: n.rdata = {s.mlv, s.msd};
        `OFS_SCRATCH: n.rdata = s.scratch;
        `OFS_FEAT: n.rdata = s.feat;
        `OFS_ENH: n.rdata = s.enh;
        `OFS_TX_LVL: n.rdata = {1'b0, s.tcnt};
        `OFS_RX_LVL: n.rdata = {1'b0, s.rcnt};
        `OFS_FLOW_STAT: n.rdata = {4'h0, s.xs};
        default: n.rdata = 8'h00;
      endcase
    end

    // host writes: control side of each shared offset
    if (wr) begin
      case (a)
        `OFS_IMASK: begin
          if (!dl) begin
            n.imask = merge(s.imask, w, `IM_EXT_MASK, ext) & ~`IM_RSVD;
          end
        end
        `OFS_ISRC: begin
          if (!dl) begin
            n.fifo_ctl = merge(s.fifo_ctl, w, `FC_EXT_MASK, ext) & `FC_KEEP;
          end
        end
        `OFS_LINE_CTL: n.line_ctl = w;
        `OFS_MODEM_CTL: n.modem_ctl = merge(s.modem_ctl, w, `MC_EXT_MASK, ext);
        `OFS_MODEM_STAT: n.tdly = merge(s.tdly, w, `MSW_EXT_MASK, ext);
        `OFS_SCRATCH: n.scratch = w;
        `OFS_FEAT: n.feat = w;
        `OFS_ENH: n.enh = w;
        `OFS_TX_LVL: n.tx_thr = w;
        `OFS_RX_LVL: n.rx_thr = w;
        `OFS_FLOW_STAT, `OFS_STOP2, `OFS_RESUME1, `OFS_RESUME2: begin
          n.fchr[a[1:0]] = w;
        end
        default: ;
      endcase
    end

    // pins idle high in loopback; general outputs never reach a pin
    n.pins_n = n.modem_ctl[`LOOP_BIT] ? `DRV_IDLE
             : ~{n.modem_ctl[`RTS_BIT], n.modem_ctl[`DTR_BIT]};
  end

  // one register for the whole channel
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
      s.isrc <= `ISR_NONE;
      s.pins_n <= `DRV_IDLE;
      s.s1 <= `PIN_IDLE;
      s.s2 <= `PIN_IDLE;
      s.s3 <= `PIN_IDLE;
    end else begin
      s <= n;
    end
  end

  // every output straight from a flop
  assign host_rdata_o = s.rdata;
  assign irq_o = s.irq;
  assign irq_src_o = s.isrc;
  assign tx_valid_o = s.txv;
  assign dtr_n_o = s.pins_n[0];
  assign rts_n_o = s.pins_n[1];
  assign line_ctrl_o = s.line_ctl;
  assign feature_ctrl_o = s.feat;
  assign enh_func_o = s.enh;
  assign turnaround_o = s.tdly;
  assign flow_chars_o = s.fchr;

  // checks on the behaviour above
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  mask_gate_a: assert property (((s.imask & `IM_LOW) == 8'h00) |=> !irq_o)
    else $error("interrupt raised with all sources masked");
  rx_trig_a: assert property ((s.imask[`IM_RX] && fen && rx_lvl) |=> irq_o && irq_src_o != `ISR_NONE)
    else $error("rx trigger reached without interrupt");
  rx_clear_a: assert property (((s.imask & `IM_LOW) == `IM_RX_ONLY && !rx_lvl) |=> irq_src_o == `ISR_NONE)
    else $error("rx interrupt held below trigger");
  data_ready_a: assert property (lsr_rd |=> host_rdata_o[0] == ($past(s.rcnt) != '0))
    else $error("data ready bit wrong");
  overrun_a: assert property ((rx_valid_i && !rx_ready_o) |=> s.ovr)
    else $error("overrun not flagged");
  top_err_a: assert property (lsr_rd && s.rcnt != '0
                              |=> host_rdata_o[4:2] == $past({rx_top.brk, rx_top.fe, rx_top.pe}))
    else $error("top byte error bits wrong");
  tx_empty_a: assert property (lsr_rd |=> host_rdata_o[5] == ($past(s.tcnt) == '0))
    else $error("tx empty bit wrong");
  all_empty_a: assert property (lsr_rd |=> host_rdata_o[6] == $past(s.tcnt == '0 && !tsr_busy_i))
    else $error("transmitter empty bit wrong");
  fifo_err_a: assert property (lsr_rd |=> host_rdata_o[7] == ($past(s.ecnt) != '0))
    else $error("fifo error bit wrong");
  ext_lock_a: assert property ((wr && a == `OFS_MODEM_CTL && !ext)
                               |=> (s.modem_ctl & `MC_EXT_MASK) == $past(s.modem_ctl & `MC_EXT_MASK))
    else $error("enhanced bits changed while locked");
  flow_clr_a: assert property ((rd && a == `OFS_FLOW_STAT && flow_evt_i == 4'h0)
                               |=> s.xs == 4'h0 && host_rdata_o[7:4] == 4'h0)
    else $error("flow status not cleared on read");
  lsr_clr_a: assert property ((lsr_rd && !ls_set) |=> !s.lsr_p)
    else $error("line interrupt survives status read");
  tx_irq_a: assert property ($fell(s.tcnt != '0) |-> s.tx_p)
    else $error("no tx ready on fifo empty");
  route_a: assert property ((rd && a == `OFS_TX_LVL) |=> $stable(s.tx_thr))
    else $error("read disturbed write-side register");
  level_a: assert property ((rd && a == `OFS_RX_LVL) |=> host_rdata_o == {1'b0, $past(s.rcnt)})
    else $error("rx level read wrong");

  rx_irq_c: cover property (s.imask[`IM_RX] && rx_lvl ##1 irq_o);
  tx_empty_c: cover property ($fell(s.tcnt != '0) && fen);
  overrun_c: cover property (rx_valid_i && !rx_ready_o);
  reissue_c: cover property (lsr_rd ##[1:20] s.lsr_p);
endmodule : uart_channel

// >>> serial_end_model.sv
/*
  Serial side model: queues received chars into the channel, takes
  transmit chars and keeps its shifter busy for a while after each.
  Assumes the bench queues chars with send and drives stall_i.
*/
module serial_end_model (
  input  wire logic       core_clk_i,
  input  wire logic       nrst_i,
  input  wire logic       stall_i,
  input  wire logic       rx_ready_i,
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  output logic [2:0]      rx_err_o,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o,
  output logic            tsr_busy_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [10:0] rxq[$];
  logic [7:0]  txq[$];
  logic        took;
  int          busy;
  task automatic send(input logic [2:0] e, input logic [7:0] d);
    rxq.push_back({e, d});
  endtask : send
  // idle values at time zero
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h00;
    rx_err_o   = 3'h0;
    tx_ready_o = 1'b0;
    tsr_busy_o = 1'b0;
    took       = 1'b0;
    busy       = 0;
  end
  // handshakes are judged on the sampling edge only
  always @(posedge core_clk_i) begin
    took <= nrst_i && rx_valid_o && rx_ready_i;
    if (tx_valid_i && tx_ready_o) begin
      txq.push_back(tx_data_i);
      busy <= 20;
    end else if (busy > 0) begin
      busy <= busy - 1;
    end
  end
  // outputs move off the edge; a char is held until taken, a free line toggles
  always @(negedge core_clk_i) begin
    if (took) begin
      void'(rxq.pop_front());
    end
    rx_valid_o <= rxq.size() != 0;
    rx_data_o  <= (rxq.size() != 0) ? rxq[0][7:0] : ~rx_data_o;
    rx_err_o   <= (rxq.size() != 0) ? rxq[0][10:8] : ~rx_err_o;
    tx_ready_o <= !stall_i;
    tsr_busy_o <= busy != 0;
  end
endmodule : serial_end_model

// >>> tb_top.sv
/*
  Self-checking bench of one serial channel register block.
  Assumes the serial side model and single-cycle host strobes.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import uart_ch_pkg::*;
  logic       clk, nrst, cs, rd, wr, stall, irq, rxv, rxr, txv, txr, busy, dtr_n, rts_n;
  logic [3:0] addr, fevt, src, mdm;
  logic [7:0] wd, rdat, rq, rxd, txd, lc, fct, ef, td;
  logic [31:0] fch;
  logic [2:0] rxe;
  int         miscompares, comparisons;

  uart_channel dut (.core_clk_i(clk), .nrst_i(nrst), .host_cs_i(cs), .host_rd_i(rd), .host_wr_i(wr),
    .host_addr_i(addr), .host_wdata_i(wd), .host_rdata_o(rdat), .irq_o(irq), .irq_src_o(src),
    .rx_valid_i(rxv), .rx_data_i(rxd), .rx_err_i(rxe), .rx_ready_o(rxr), .tx_valid_o(txv),
    .tx_data_o(txd), .tx_ready_i(txr), .tsr_busy_i(busy), .modem_n_i(mdm), .flow_evt_i(fevt),
    .dtr_n_o(dtr_n), .rts_n_o(rts_n), .line_ctrl_o(lc), .feature_ctrl_o(fct), .enh_func_o(ef),
    .turnaround_o(td), .flow_chars_o(fch));
  serial_end_model pe (.core_clk_i(clk), .nrst_i(nrst), .stall_i(stall), .rx_ready_i(rxr),
    .rx_valid_o(rxv), .rx_data_o(rxd), .rx_err_o(rxe), .tx_valid_i(txv), .tx_data_i(txd),
    .tx_ready_o(txr), .tsr_busy_o(busy));

  // 250 MHz core clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // host cycles: strobes for one cycle, data taken once settled
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk) {cs, wr, addr, wd} = {2'b11, a, d};
    @(negedge clk) {cs, wr} = 2'b00;
  endtask : wreg
  task automatic rchk(input string n, input logic [3:0] a, input logic [7:0] e);
    @(negedge clk) {cs, rd, addr} = {2'b11, a};
    @(negedge clk) {cs, rd} = 2'b00;
    @(negedge clk) rq = rdat;
    chk(n, e, rq);
  endtask : rchk
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  task automatic t_reset;
    chk("irq source", 8'h01, {4'h0, src});
    chk("modem outs", 8'h03, {6'h0, dtr_n, rts_n});
    rchk("line status", 4'h5, 8'h60);
    rchk("unused read", 4'hd, 8'h00);
    wreg(4'h7, 8'ha5);
    rchk("scratch", 4'h7, 8'ha5);
    $display("test reset done");
  endtask : t_reset

  task automatic t_level;
    wreg(4'h2, 8'h01);
    wreg(4'h1, 8'h00);
    for (int i = 0; i < 3; i++) pe.send(3'h0, 8'h30 + i[7:0]);
    idle(10);
    rchk("rx level", 4'hb, 8'h03);
    rchk("line status", 4'h5, 8'h61);
    for (int i = 0; i < 3; i++) rchk("rx data", 4'h0, 8'h30 + i[7:0]);
    rchk("line status", 4'h5, 8'h60);
    rchk("rx level", 4'hb, 8'h00);
    $display("test level done");
  endtask : t_level

  task automatic t_trigger;
    wreg(4'h2, 8'h41);
    wreg(4'h1, 8'h01);
    for (int i = 0; i < 15; i++) pe.send(3'h0, i[7:0]);
    idle(25);
    chk("irq below trigger", 8'h01, {7'h0, ~irq});
    pe.send(3'h0, 8'h0f);
    idle(8);
    chk("irq at trigger", 8'h14, {3'h0, irq, src});
    wreg(4'h1, 8'h00);
    idle(3);
    chk("irq masked", 8'h01, {3'h0, irq, src});
    wreg(4'h1, 8'h01);
    idle(3);
    chk("irq unmasked", 8'h14, {3'h0, irq, src});
    for (int i = 0; i < 16; i++) begin
      rchk("rx data", 4'h0, i[7:0]);
      if (i == 0) chk("irq below again", 8'h01, {3'h0, irq, src});
    end
    $display("test trigger done");
  endtask : t_trigger

  task automatic t_errors;
    wreg(4'h1, 8'h04);
    pe.send(3'h0, 8'h55);
    pe.send(3'h1, 8'haa);
    idle(10);
    chk("line irq", 8'h16, {3'h0, irq, src});
    rchk("line status", 4'h5, 8'he1);
    idle(3);
    chk("line irq cleared", 8'h01, {3'h0, irq, src});
    rchk("rx data", 4'h0, 8'h55);
    idle(4);
    chk("line irq at top", 8'h16, {3'h0, irq, src});
    rchk("line status", 4'h5, 8'he5);
    rchk("rx data", 4'h0, 8'haa);
    rchk("line status", 4'h5, 8'h60);
    $display("test errors done");
  endtask : t_errors

  task automatic t_overrun;
    wreg(4'h1, 8'h00);
    wreg(4'h2, 8'h01);
    for (int i = 0; i < 67; i++) pe.send(3'h0, i[7:0]);
    idle(150);
    chk("rx ready", 8'h00, {7'h0, rxr});
    rchk("rx level", 4'hb, 8'h40);
    rchk("line status", 4'h5, 8'h63);
    for (int i = 0; i < 67; i++) rchk("rx data", 4'h0, i[7:0]);
    rchk("line status", 4'h5, 8'h62);
    rchk("line status", 4'h5, 8'h60);
    $display("test overrun done");
  endtask : t_overrun

  task automatic t_tx;
    int n;
    stall = 1'b1;
    wreg(4'h1, 8'h02);
    wreg(4'h0, 8'h11);
    wreg(4'h0, 8'h22);
    rchk("line status", 4'h5, 8'h00);
    rchk("tx level", 4'ha, 8'h02);
    stall = 1'b0;
    n = 0;
    while (pe.txq.size() < 2 && n < 50) begin
      idle(1);
      n++;
    end
    chk("tx order", 8'h22, pe.txq.size() == 2 ? pe.txq[1] : 8'h00);
    rchk("line status", 4'h5, 8'h20);
    chk("tx irq", 8'h12, {3'h0, irq, src});
    rchk("irq source reg", 4'h2, 8'hc2);
    idle(2);
    chk("tx irq read", 8'h01, {3'h0, irq, src});
    idle(20);
    rchk("line status", 4'h5, 8'h60);
    $display("test transmit done");
  endtask : t_tx

  task automatic t_enh;
    wreg(4'h1, 8'hff);
    rchk("mask plain", 4'h1, 8'h0f);
    wreg(4'h4, 8'h0f);
    rchk("modem ctl plain", 4'h4, 8'h03);
    wreg(4'h6, 8'hf3);
    chk("delay locked", 8'h03, td);
    wreg(4'h9, 8'h10);
    chk("enh copy", 8'h10, ef);
    wreg(4'h1, 8'hff);
    rchk("mask enhanced", 4'h1, 8'hef);
    wreg(4'h1, 8'h00);
    wreg(4'h4, 8'h1c);
    idle(8);
    rchk("loop status", 4'h6, 8'hcc);
    chk("loop dtr", 8'h01, {7'h0, dtr_n});
    wreg(4'h4, 8'h00);
    wreg(4'h9, 8'h00);
    $display("test enhanced done");
  endtask : t_enh

  task automatic t_flow;
    @(negedge clk) fevt = 4'ha;
    @(negedge clk) fevt = 4'h0;
    rchk("flow status", 4'hc, 8'h0a);
    rchk("flow cleared", 4'hc, 8'h00);
    wreg(4'ha, 8'h33);
    rchk("tx level shared", 4'ha, 8'h00);
    wreg(4'h5, 8'hff);
    rchk("line status shared", 4'h5, 8'h60);
    wreg(4'hc, 8'h13);
    wreg(4'hf, 8'h11);
    chk("stop char one", 8'h13, fch[7:0]);
    chk("resume char two", 8'h11, fch[31:24]);
    wreg(4'h3, 8'h1b);
    wreg(4'h8, 8'h05);
    chk("line ctl copy", 8'h1b, lc);
    chk("feature copy", 8'h05, fct);
    // cts pin goes active; three sync flops before it shows
    mdm = 4'he;
    idle(6);
    rchk("modem pins", 4'h6, 8'h1d);
    $display("test flow done");
  endtask : t_flow

  // main sequence after a five cycle reset
  initial begin
    {nrst, cs, rd, wr, stall, addr, fevt, wd} = '0;
    mdm = 4'hf;
    miscompares = 0;
    comparisons = 0;
    repeat (5) @(posedge clk);
    @(negedge clk) nrst = 1'b1;
    t_reset();
    t_level();
    t_trigger();
    t_errors();
    t_overrun();
    t_tx();
    t_enh();
    t_flow();
    close_out();
  end

  // hang guard at 50000 cycles, well past the expected several hundred cycles
  initial begin
    #200000;
    miscompares++;
    close_out();
  end
endmodule : tb_top
